// *** ctc_pkg.sv ***
// package: register map, field positions and codes of the cascaded timer
package ctc_pkg;
  localparam logic [23:0] CTC_ADDR_CH5_CONTROL = 24'hFFEA41;
  localparam logic [23:0] CTC_ADDR_CH4_COUNTER = 24'hFFFEE6;
  localparam logic [23:0] CTC_ADDR_CH4_COMPARE_A = 24'hFFFEE8;
  localparam logic [23:0] CTC_ADDR_CH4_COMPARE_B = 24'hFFFEEA;
  localparam logic [23:0] CTC_ADDR_RUN_CONTROL = 24'hFFFFBC;
  localparam logic [23:0] CTC_ADDR_CH4_CONTROL = 24'hFFFEE0;
  localparam logic [23:0] CTC_ADDR_CH4_MODE = 24'hFFFEE1;
  localparam logic [23:0] CTC_ADDR_CH5_COUNTER = 24'hFFEA46;
  localparam int CTC_CLR_LSB = 5;
  localparam int CTC_EDGE_LSB = 3;
  localparam int CTC_PSC_LSB = 0;
  localparam logic [2:0] CTC_CLR_NONE = 3'h0;
  localparam logic [2:0] CTC_CLR_CMP_B = 3'h2;
  localparam logic [1:0] CTC_EDGE_FALL = 2'h0;
  localparam logic [1:0] CTC_EDGE_RISE = 2'h1;
  localparam logic [2:0] CTC_PSC_DIV1 = 3'h0;
  localparam logic [2:0] CTC_PSC_CASCADE = 3'h7;
  localparam logic [3:0] CTC_MODE_PWM1 = 4'h2;
  localparam logic [7:0] CTC_CTRL_RESET = 8'h00;
  localparam logic [7:0] CTC_RUN_RESET = 8'h00;
  localparam logic [15:0] CTC_CNT_RESET = 16'h0000;
  localparam logic [15:0] CTC_CMP_RESET = 16'hFFFF;
  localparam logic [3:0] CTC_MODE_RESET = 4'h0;
endpackage

// *** ctc_edge_counter.sv ***
// one 16-bit channel counter with prescaler, edge select and clear
`timescale 1ns/1ns
`default_nettype none
module ctc_edge_counter
  import ctc_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [2:0] prescaler_field,
  input wire logic [1:0] edge_select_field,
  input wire logic cascade_tick,
  input wire logic clear_req,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic src_reg;
  logic [WIDTH-1:0] cnt_reg;
  logic wrap_reg;
  wire logic src_level;
  wire logic rise;
  wire logic fall;
  wire logic tick;
  wire logic at_max;
  // ************
  // clock source
  // ************
  assign div_next = div_reg + 7'h01;
  assign src_level = (prescaler_field == CTC_PSC_CASCADE) ? cascade_tick :
                     div_reg[prescaler_field];
  assign rise = src_level & ~src_reg;
  assign fall = ~src_level & src_reg;
  assign tick = !run ? 1'b0 :
                (prescaler_field == CTC_PSC_DIV1) ? 1'b1 :
                (prescaler_field == CTC_PSC_CASCADE) ? cascade_tick :
                (edge_select_field == CTC_EDGE_FALL) ? fall :
                (edge_select_field == CTC_EDGE_RISE) ? rise : (rise | fall);
  assign at_max = (cnt_reg == {WIDTH{1'b1}});
  assign count = cnt_reg;
  assign wrap = wrap_reg;
  // ************
  // counter
  // ************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_reg <= 7'h00;
      src_reg <= 1'b0;
      cnt_reg <= CTC_CNT_RESET;
      wrap_reg <= 1'b0;
    end
    else if (ce)
    begin
      div_reg <= div_next;
      src_reg <= src_level;
      wrap_reg <= tick & at_max & ~wr_en & ~clear_req;
      if (wr_en)
        cnt_reg <= wr_data;
      else if (clear_req)
        cnt_reg <= CTC_CNT_RESET;
      else if (tick)
        cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** ctc_timer.sv ***
// top: channel 4 and 5 counters, compares, run control, pulse output
`timescale 1ns/1ns
`default_nettype none
module ctc_timer
  import ctc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic ch4_pin_a,
  output logic [5:0] run_bits
);
  logic [7:0] ch5_control_reg;
  logic [7:0] ch4_control_reg;
  logic [3:0] mode_reg;
  logic [5:0] run_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] rdata_reg;
  logic pin_reg;
  logic [15:0] rdata_next;
  logic pin_next;
  wire logic [15:0] ch4_counter;
  wire logic [15:0] ch5_counter;
  wire logic ch5_wrap;
  wire logic match_a;
  wire logic match_b;
  wire logic ch4_clear;
  wire logic ch5_clear;
  wire logic pwm_mode;
  wire logic wr_c5;
  wire logic wr_c4;
  wire logic wr_cnt4;
  wire logic wr_cnt5;
  wire logic wr_a;
  wire logic wr_b;
  wire logic wr_run;
  wire logic wr_mode;
  // ************
  // address decode
  // ************
  assign wr_c5 = wr && (addr == CTC_ADDR_CH5_CONTROL);
  assign wr_c4 = wr && (addr == CTC_ADDR_CH4_CONTROL);
  assign wr_mode = wr && (addr == CTC_ADDR_CH4_MODE);
  assign wr_cnt4 = wr && (addr == CTC_ADDR_CH4_COUNTER);
  assign wr_cnt5 = wr && (addr == CTC_ADDR_CH5_COUNTER);
  assign wr_a = wr && (addr == CTC_ADDR_CH4_COMPARE_A);
  assign wr_b = wr && (addr == CTC_ADDR_CH4_COMPARE_B);
  assign wr_run = wr && (addr == CTC_ADDR_RUN_CONTROL);
  always_comb
  begin
    if (addr == CTC_ADDR_CH5_CONTROL)
      rdata_next = {8'h00, ch5_control_reg};
    else if (addr == CTC_ADDR_CH4_CONTROL)
      rdata_next = {8'h00, ch4_control_reg};
    else if (addr == CTC_ADDR_CH4_MODE)
      rdata_next = {12'h000, mode_reg};
    else if (addr == CTC_ADDR_CH4_COUNTER)
      rdata_next = ch4_counter;
    else if (addr == CTC_ADDR_CH5_COUNTER)
      rdata_next = ch5_counter;
    else if (addr == CTC_ADDR_CH4_COMPARE_A)
      rdata_next = cmp_a_reg;
    else if (addr == CTC_ADDR_CH4_COMPARE_B)
      rdata_next = cmp_b_reg;
    else if (addr == CTC_ADDR_RUN_CONTROL)
      rdata_next = {10'h000, run_reg};
    else
      rdata_next = 16'h0000;
  end
  // ************
  // compare and clear
  // ************
  assign match_a = (ch4_counter == cmp_a_reg);
  assign match_b = (ch4_counter == cmp_b_reg);
  assign ch4_clear = (ch4_control_reg[CTC_CLR_LSB +: 3] == CTC_CLR_CMP_B) && match_b;
  assign ch5_clear = (ch5_control_reg[CTC_CLR_LSB +: 3] != CTC_CLR_NONE) && 1'b0;
  assign pwm_mode = (mode_reg == CTC_MODE_PWM1);
  always_comb
  begin
    pin_next = pin_reg;
    if (!pwm_mode)
      pin_next = 1'b0;
    else if (match_a)
      pin_next = 1'b1;
    else if (match_b)
      pin_next = 1'b0;
  end
  // ************
  // counters
  // ************
  ctc_edge_counter #(.WIDTH(16)) u_ch5
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(run_reg[5]),
    .prescaler_field(ch5_control_reg[CTC_PSC_LSB +: 3]),
    .edge_select_field(ch5_control_reg[CTC_EDGE_LSB +: 2]),
    .cascade_tick(1'b0),
    .clear_req(ch5_clear),
    .wr_en(wr_cnt5),
    .wr_data(wdata),
    .count(ch5_counter),
    .wrap(ch5_wrap)
  );
  ctc_edge_counter #(.WIDTH(16)) u_ch4
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(run_reg[4]),
    .prescaler_field(ch4_control_reg[CTC_PSC_LSB +: 3]),
    .edge_select_field(ch4_control_reg[CTC_EDGE_LSB +: 2]),
    .cascade_tick(ch5_wrap),
    .clear_req(ch4_clear),
    .wr_en(wr_cnt4),
    .wr_data(wdata),
    .count(ch4_counter),
    .wrap()
  );
  // ************
  // registers
  // ************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ch5_control_reg <= CTC_CTRL_RESET;
      ch4_control_reg <= CTC_CTRL_RESET;
      mode_reg <= CTC_MODE_RESET;
      run_reg <= CTC_RUN_RESET[5:0];
      cmp_a_reg <= CTC_CMP_RESET;
      cmp_b_reg <= CTC_CMP_RESET;
      rdata_reg <= 16'h0000;
      pin_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_c5)
        ch5_control_reg <= wdata[7:0];
      if (wr_c4)
        ch4_control_reg <= wdata[7:0];
      if (wr_mode)
        mode_reg <= wdata[3:0];
      if (wr_run)
        run_reg <= wdata[5:0];
      if (wr_a)
        cmp_a_reg <= wdata;
      if (wr_b)
        cmp_b_reg <= wdata;
      rdata_reg <= rd ? rdata_next : 16'h0000;
      pin_reg <= pin_next;
    end
  end
  assign rdata = rdata_reg;
  assign ch4_pin_a = pin_reg;
  assign run_bits = run_reg;
endmodule
`default_nettype wire

// *** ctc_timer_checker.sv ***
// checker: port-level properties of the cascaded timer
`timescale 1ns/1ns
`default_nettype none
module ctc_timer_checker
  import ctc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic ch4_pin_a,
  input wire logic [5:0] run_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // decodes
  // ****************
  wire w_run = ce && wr && addr == CTC_ADDR_RUN_CONTROL;
  wire r_run = ce && rd && addr == CTC_ADDR_RUN_CONTROL;
  wire w_cmp = ce && wr && addr == CTC_ADDR_CH4_COMPARE_A;
  wire r_cmp = ce && rd && addr == CTC_ADDR_CH4_COMPARE_A;
  wire w_c5 = ce && wr && addr == CTC_ADDR_CH5_CONTROL;
  wire r_c5 = ce && rd && addr == CTC_ADDR_CH5_CONTROL;
  wire w_cnt = ce && wr && addr == CTC_ADDR_CH4_COUNTER;
  wire r_cnt = ce && rd && addr == CTC_ADDR_CH4_COUNTER;
  wire w_mode = ce && wr && addr == CTC_ADDR_CH4_MODE;
  idle_read_zero_a: assert property (ce && !rd |=> rdata == 16'h0000)
    else $error("read data not zero");
  run_write_a: assert property (w_run |=> run_bits == $past(wdata[5:0]))
    else $error("run bits not written");
  run_hold_a: assert property (!w_run |=> $stable(run_bits))
    else $error("run bits changed");
  run_read_a: assert property (r_run |=> rdata == {10'h000, $past(run_bits)})
    else $error("run read wrong");
  cmp_readback_a: assert property (w_cmp ##1 r_cmp |=> rdata == $past(wdata, 2))
    else $error("compare readback wrong");
  ctrl_readback_a: assert property (w_c5 ##1 r_c5 |=> rdata == {8'h00, $past(wdata[7:0], 2)})
    else $error("control readback wrong");
  halt_readback_a: assert property (w_cnt && !run_bits[4] ##1 r_cnt |=> rdata == $past(wdata, 2))
    else $error("halted counter not held");
  pwm_off_a: assert property (w_mode && wdata[3:0] != CTC_MODE_PWM1 |-> ##[1:3] !ch4_pin_a)
    else $error("pin high outside pulse mode");
  freeze_a: assert property (!ce |=> $stable(ch4_pin_a) && $stable(run_bits))
    else $error("state moved with enable low");
  cover property (r_cnt);
  cover property ($rose(ch4_pin_a));
  cover property (w_run && wdata[5:4] == 2'h3);
endmodule
`default_nettype wire

// *** ctc_timer_test.sv ***
// testbench: registers, run control, cascade and pulse output
`timescale 1ns/1ns
`default_nettype none
module ctc_timer_test;
  import ctc_pkg::*;
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, chk = 0, chk_d = 0, rd_d = 0;
  logic [23:0] addr = 0;
  logic [15:0] wdata = 0, rdata, last, v, d;
  logic ch4_pin_a;
  logic [5:0] run_bits;
  logic [15:0] expq[$];
  int fails = 0, compares = 0, hi;
  initial forever #25 clk = ~clk;
  ctc_timer ctc_timer_inst (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ch4_pin_a(ch4_pin_a), .run_bits(run_bits));
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [23:0] a, input logic [15:0] dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask
  task automatic rreg(input logic [23:0] a, input logic [15:0] e, input logic c);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    chk <= c;
    if (c)
      expq.push_back(e);
  endtask
  task automatic sample(input logic [23:0] a);
    rreg(a, 16'h0000, 1'b0);
    repeat (3) tick;
    v = last;
  endtask
  always @(posedge clk)
  begin
    chk_d <= rd && chk;
    rd_d <= rd;
    if (rd_d)
      last = rdata;
    if (chk_d)
      check(rdata, expq.pop_front());
  end
  initial
  begin
    #(50 * 5000);
    fails++;
    finish_test;
  end
  initial
  begin
    v = $urandom(16436);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rreg(CTC_ADDR_CH5_CONTROL, 16'h0000, 1'b1);
    rreg(CTC_ADDR_CH4_COMPARE_B, CTC_CMP_RESET, 1'b1);
    rreg(CTC_ADDR_RUN_CONTROL, 16'h0000, 1'b1);
    repeat (4)
    begin
      d = $urandom;
      wreg(CTC_ADDR_CH5_CONTROL, d);
      rreg(CTC_ADDR_CH5_CONTROL, {8'h00, d[7:0]}, 1'b1);
      wreg(CTC_ADDR_CH4_COUNTER, ~d);
      rreg(CTC_ADDR_CH4_COUNTER, ~d, 1'b1);
      wreg(CTC_ADDR_CH4_COMPARE_A, d);
      rreg(CTC_ADDR_CH4_COMPARE_A, d, 1'b1);
      wreg(24'hFFFEE4, d);
      rreg(24'hFFFEE4, 16'h0000, 1'b1);
    end
    wreg(CTC_ADDR_CH4_COMPARE_B, 16'h1234);
    tick;
    ce <= 1'b0;
    wreg(CTC_ADDR_CH4_COMPARE_B, 16'h4321);
    tick;
    ce <= 1'b1;
    rreg(CTC_ADDR_CH4_COMPARE_B, 16'h1234, 1'b1);
    $display("register test done");
    wreg(CTC_ADDR_CH5_CONTROL, 16'h0000);
    wreg(CTC_ADDR_CH5_COUNTER, 16'hFFF0);
    wreg(CTC_ADDR_RUN_CONTROL, 16'h0020);
    sample(CTC_ADDR_CH5_COUNTER);
    repeat (36) tick;
    rreg(CTC_ADDR_CH5_COUNTER, v + 16'h0028, 1'b1);
    wreg(CTC_ADDR_RUN_CONTROL, 16'h0000);
    repeat (2) tick;
    sample(CTC_ADDR_CH5_COUNTER);
    repeat (6) tick;
    rreg(CTC_ADDR_CH5_COUNTER, v, 1'b1);
    wreg(CTC_ADDR_CH5_CONTROL, 16'h0001);
    wreg(CTC_ADDR_RUN_CONTROL, 16'h0020);
    sample(CTC_ADDR_CH5_COUNTER);
    repeat (36) tick;
    rreg(CTC_ADDR_CH5_COUNTER, v + 16'h000A, 1'b1);
    wreg(CTC_ADDR_RUN_CONTROL, 16'h0000);
    wreg(CTC_ADDR_CH5_CONTROL, 16'h0000);
    $display("count test done");
    wreg(CTC_ADDR_CH4_CONTROL, 16'h0007);
    wreg(CTC_ADDR_CH4_COUNTER, 16'h0000);
    wreg(CTC_ADDR_CH5_COUNTER, 16'hFFF0);
    wreg(CTC_ADDR_RUN_CONTROL, 16'h0030);
    repeat (40) tick;
    check({10'h000, run_bits}, 16'h0030);
    wreg(CTC_ADDR_RUN_CONTROL, 16'h0000);
    tick;
    rreg(CTC_ADDR_CH4_COUNTER, 16'h0001, 1'b1);
    $display("cascade test done");
    wreg(CTC_ADDR_CH4_COMPARE_A, 16'h0004);
    wreg(CTC_ADDR_CH4_COMPARE_B, 16'h000A);
    wreg(CTC_ADDR_CH4_CONTROL, 16'h0040);
    wreg(CTC_ADDR_CH4_MODE, 16'h0002);
    wreg(CTC_ADDR_CH4_COUNTER, 16'h0000);
    wreg(CTC_ADDR_RUN_CONTROL, 16'h0010);
    repeat (30) tick;
    hi = 0;
    repeat (44)
    begin
      tick;
      hi += ch4_pin_a;
    end
    check(hi[15:0], 16'h0018);
    wreg(CTC_ADDR_CH4_MODE, 16'h0000);
    repeat (3) tick;
    check({15'h0000, ch4_pin_a}, 16'h0000);
    $display("pulse test done");
    repeat (3) tick;
    finish_test;
  end
endmodule
bind ctc_timer ctc_timer_checker ctc_timer_checker_inst (.clk(clk), .rst(rst), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ch4_pin_a(ch4_pin_a),
  .run_bits(run_bits));
`default_nettype wire
